// ===== include/wcc_pkg.sv
// Shared constants, types and checksum functions of the write checksum link.
package wcc_pkg;

  // ==========================================================================
  // Frame geometry
  localparam int DATA_BITS = 128;
  localparam int MASK_BITS = 16;
  localparam int LANE_BITS = 18;
  localparam int MASK_LANE = 16;
  localparam int GROUP_LANES = 8;
  localparam int NARROW_LANES = 4;
  localparam int FRAME_BEATS = 10;
  localparam int DATA_BEATS = 8;
  localparam int CHOP_HALF = 4;
  localparam int CRC_BEAT = 8;
  localparam int CRC_BEAT_HI = 9;
  localparam logic [3:0] LAST_BEAT_CRC = 4'h9;
  localparam logic [3:0] LAST_BEAT_PLAIN = 4'h7;

  // ==========================================================================
  // Checksum
  localparam int CW_BITS = 72;
  localparam int CW_ONES_LSB = 32;
  localparam int CRC_BITS = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ==========================================================================
  // Timing counts and reset values
  localparam logic [3:0] ALERT_PULSE_CYCLES = 4'h6;
  localparam logic [2:0] CHECK_WAIT_CYCLES = 3'h5;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic ALERT_N_RESET = 1'b1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {WCC_X4 = 2'h0, WCC_X8 = 2'h1, WCC_X16 = 2'h2} wcc_width_t;
  typedef enum logic [1:0] {WCC_RX_IDLE = 2'h0, WCC_RX_RECV = 2'h1, WCC_RX_CHECK = 2'h3} wcc_rx_state_t;
  typedef enum logic [1:0] {WCC_TX_IDLE = 2'h0, WCC_TX_SEND = 2'h1, WCC_TX_WAIT = 2'h3} wcc_tx_state_t;
  typedef logic [FRAME_BEATS-1:0][LANE_BITS-1:0] wcc_frame_t;

  // ==========================================================================
  // Functions
  // Serial division, code word bit 71 first, from an all-zero register.
  function automatic logic [CRC_BITS-1:0] wcc_crc8(input logic [CW_BITS-1:0] d);
    logic [CRC_BITS-1:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = CW_BITS - 1; i >= 0; i--)
    begin
      fb = c[CRC_BITS-1] ^ d[i];
      c = {c[CRC_BITS-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Code word of byte group g as carried on the wire in beats 0 to 7.
  function automatic logic [CW_BITS-1:0] wcc_code_word(input wcc_frame_t f, input int g, input logic narrow);
    logic [CW_BITS-1:0] w;
    w = '1;
    for (int k = 0; k < DATA_BEATS; k++)
    begin
      for (int l = 0; l < GROUP_LANES; l++)
        w[GROUP_LANES*l+k] = f[k][GROUP_LANES*g+l];
      w[GROUP_LANES*DATA_BEATS+k] = f[k][MASK_LANE+g];
    end
    if (narrow)
      w[CW_BITS-1:CW_ONES_LSB] = '1;
    return w;
  endfunction

  // Checksum of byte group g as carried in beat 8, or in beats 8 and 9 for four-bit devices.
  function automatic logic [CRC_BITS-1:0] wcc_rx_crc(input wcc_frame_t f, input int g, input logic narrow);
    logic [CRC_BITS-1:0] c;
    for (int l = 0; l < CRC_BITS; l++)
    begin
      if (narrow)
        c[l] = (l < NARROW_LANES) ? f[CRC_BEAT][l] : f[CRC_BEAT_HI][l-NARROW_LANES];
      else
        c[l] = f[CRC_BEAT][GROUP_LANES*g+l];
    end
    return c;
  endfunction

endpackage

// ===== include/wcc_link_if.sv
// Write frame link between the controller end and the memory end.
`timescale 1ns/1ns
interface wcc_link_if import wcc_pkg::*; ();
  logic beat_valid;
  logic [LANE_BITS-1:0] beat;
  logic alert_n;
  logic link_ready;

  modport ctrl (output beat_valid, output beat, input alert_n, input link_ready);
  modport dram (input beat_valid, input beat, output alert_n, output link_ready);
endinterface

// ===== src/wcc_dram_end.sv
// Memory end: frame receiver, checksum check, alert and array write buffer.
`timescale 1ns/1ns

// How it works
// - Recompute received checksum, alert on mismatch.
// - Checksum polynomial x^8+x^2+x+1, combinational.
// - Bit 71 shifted first, zero start.
// - Four-bit devices force code bits 71:32 high.
// - Byte devices add mask lane or ones.
// - Sixteen-bit devices check two byte groups separately.
// - Controller drives ones during the tenth beat, except four-bit devices (checksum there).
// - Narrow lanes carry checksum on beats eight, nine.
// - Unmasked writes commit even when checksum fails.
// - Controller rewrites location after unmasked failure.
// - Masked mode drops failing bursts before array.
// - Checksum on raw bits; inversion undone afterwards.
// - No readout-register or per-device writes allowed while checksum is on.
// - Eight-beat bursts use fixed zero start order.
// - Detects single, double, odd and column errors.
// - Check bits are fixed XOR sums of bits.
// - Upper checksum byte covers upper code word.
// - Chop address bit picks transferred half.
module wcc_dram_end
  import wcc_pkg::*;
#(
  parameter logic [3:0] ALERT_CYCLES = ALERT_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  wcc_link_if.dram link,
  input wire wcc_width_t width,
  input wire logic crc_en,
  input wire logic mask_en,
  input wire logic inv_en,
  input wire logic chop_en,
  input wire logic chop_a2,
  output logic arr_valid,
  input wire logic arr_ready,
  output logic [DATA_BITS-1:0] arr_data,
  output logic [MASK_BITS-1:0] arr_mask,
  output logic crc_error
);

  // ==========================================================================
  // Array word assembly
  // Mask bit 1 means the byte is not written; halves not sent stay masked.
  function automatic logic [DATA_BITS+MASK_BITS-1:0] array_word(
    input wcc_frame_t f,
    input wcc_width_t w,
    input logic m_en,
    input logic i_en,
    input logic chop,
    input logic a2
  );
    logic [DATA_BITS-1:0] d;
    logic [MASK_BITS-1:0] m;
    logic flag;
    int p;
    d = '1;
    m = '1;
    for (int g = 0; g < 2; g++)
    begin
      for (int k = 0; k < DATA_BEATS; k++)
      begin
        if (!chop || k < CHOP_HALF)
        begin
          p = (chop && a2) ? k + CHOP_HALF : k;
          flag = f[k][MASK_LANE+g];
          if ((g == 0 && w != WCC_X4) || w == WCC_X16)
            m[GROUP_LANES*g+p] = m_en & ~flag;
          else if (g == 0)
            m[p] = 1'b0;
          for (int l = 0; l < GROUP_LANES; l++)
            d[DATA_BEATS*GROUP_LANES*g+GROUP_LANES*l+p] = f[k][GROUP_LANES*g+l] ^ (i_en & ~m_en & ~flag);
        end
      end
    end
    return {m, d};
  endfunction

  // ==========================================================================
  // State
  wcc_rx_state_t state;
  wcc_rx_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  wcc_frame_t rx;
  wcc_frame_t next_rx;
  logic [3:0] alert_cnt;
  logic [3:0] next_alert_cnt;
  logic alert_n;
  logic next_alert_n;
  logic link_ready;
  logic next_link_ready;
  logic next_crc_error;
  logic next_arr_valid;
  logic [DATA_BITS-1:0] next_arr_data;
  logic [MASK_BITS-1:0] next_arr_mask;
  logic skid_valid;
  logic next_skid_valid;
  logic [DATA_BITS-1:0] skid_data;
  logic [DATA_BITS-1:0] next_skid_data;
  logic [MASK_BITS-1:0] skid_mask;
  logic [MASK_BITS-1:0] next_skid_mask;
  logic narrow;
  logic err;
  logic push;
  logic [DATA_BITS+MASK_BITS-1:0] word;

  assign link.alert_n = alert_n;
  assign link.link_ready = link_ready;
  assign narrow = (width == WCC_X4);

  // ==========================================================================
  // Next values
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_rx = rx;
    next_alert_cnt = alert_cnt;
    next_crc_error = 1'b0;
    next_arr_valid = arr_valid;
    next_arr_data = arr_data;
    next_arr_mask = arr_mask;
    next_skid_valid = skid_valid;
    next_skid_data = skid_data;
    next_skid_mask = skid_mask;
    err = 1'b0;
    push = 1'b0;
    word = array_word(rx, width, mask_en, inv_en, chop_en, chop_a2);
    case (state)
      WCC_RX_IDLE:
      begin
        if (link.beat_valid)
        begin
          next_rx[0] = link.beat;
          next_cnt = 4'h1;
          next_state = WCC_RX_RECV;
        end
      end
      WCC_RX_RECV:
      begin
        if (link.beat_valid)
        begin
          next_rx[cnt] = link.beat;
          next_cnt = cnt + 4'h1;
          if (cnt == (crc_en ? LAST_BEAT_CRC : LAST_BEAT_PLAIN))
            next_state = WCC_RX_CHECK;
        end
      end
      WCC_RX_CHECK:
      begin
        // Raw wire bits feed the checksum; inversion is undone only in array_word.
        if (crc_en)
        begin
          err = wcc_crc8(wcc_code_word(rx, 0, narrow)) != wcc_rx_crc(rx, 0, narrow);
          if (width == WCC_X16)
            err = err | (wcc_crc8(wcc_code_word(rx, 1, 1'b0)) != wcc_rx_crc(rx, 1, 1'b0));
        end
        // Unmasked writes go ahead regardless; masked ones wait for the result.
        push = !(mask_en && err);
        next_crc_error = err;
        next_cnt = CNT_RESET;
        next_state = WCC_RX_IDLE;
      end
      default:
      begin
        next_state = WCC_RX_IDLE;
      end
    endcase

    if (err)
      next_alert_cnt = ALERT_CYCLES;
    else if (alert_cnt != 4'h0)
      next_alert_cnt = alert_cnt - 4'h1;
    next_alert_n = (next_alert_cnt == 4'h0);

    // Two-entry buffer: head drives the array, skid absorbs a stalled push.
    if (arr_valid && arr_ready)
    begin
      next_arr_valid = skid_valid;
      next_arr_data = skid_data;
      next_arr_mask = skid_mask;
      next_skid_valid = 1'b0;
    end
    if (push)
    begin
      if (!next_arr_valid)
      begin
        next_arr_valid = 1'b1;
        next_arr_data = word[DATA_BITS-1:0];
        next_arr_mask = word[DATA_BITS+MASK_BITS-1:DATA_BITS];
      end
      else
      begin
        next_skid_valid = 1'b1;
        next_skid_data = word[DATA_BITS-1:0];
        next_skid_mask = word[DATA_BITS+MASK_BITS-1:DATA_BITS];
      end
    end
    next_link_ready = !(next_arr_valid && next_skid_valid);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= WCC_RX_IDLE;
      cnt <= CNT_RESET;
      rx <= '1;
      alert_cnt <= 4'h0;
      alert_n <= ALERT_N_RESET;
      link_ready <= 1'b1;
      crc_error <= 1'b0;
      arr_valid <= 1'b0;
      arr_data <= '0;
      arr_mask <= '1;
      skid_valid <= 1'b0;
      skid_data <= '0;
      skid_mask <= '1;
    end
    else if (ce)
    begin
      state <= next_state;
      cnt <= next_cnt;
      rx <= next_rx;
      alert_cnt <= next_alert_cnt;
      alert_n <= next_alert_n;
      link_ready <= next_link_ready;
      crc_error <= next_crc_error;
      arr_valid <= next_arr_valid;
      arr_data <= next_arr_data;
      arr_mask <= next_arr_mask;
      skid_valid <= next_skid_valid;
      skid_data <= next_skid_data;
      skid_mask <= next_skid_mask;
    end
  end

endmodule

// ===== src/wcc_ctrl_end.sv
// Controller end: builds write frames with checksum and rewrites unmasked writes once after an alert.
`timescale 1ns/1ns
module wcc_ctrl_end
  import wcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  wcc_link_if.ctrl link,
  input wire wcc_width_t width,
  input wire logic crc_en,
  input wire logic mask_en,
  input wire logic inv_en,
  input wire logic chop_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [DATA_BITS-1:0] req_data,
  input wire logic [MASK_BITS-1:0] req_flags,
  input wire logic req_a2,
  input wire logic req_special,
  output logic req_refused,
  output logic crc_fail
);

  // ==========================================================================
  // Frame assembly
  function automatic wcc_frame_t build_frame(
    input logic [DATA_BITS-1:0] data,
    input logic [MASK_BITS-1:0] flags,
    input wcc_width_t w,
    input logic flag_en,
    input logic chop,
    input logic a2,
    input logic crc_on
  );
    wcc_frame_t f;
    logic [CRC_BITS-1:0] c;
    int sk;
    f = '1;
    for (int g = 0; g < 2; g++)
    begin
      if (g == 0 || w == WCC_X16)
      begin
        for (int k = 0; k < DATA_BEATS; k++)
        begin
          if (!chop || k < CHOP_HALF)
          begin
            sk = (chop && a2) ? k + CHOP_HALF : k;
            for (int l = 0; l < GROUP_LANES; l++)
              if (w != WCC_X4 || l < NARROW_LANES)
                f[k][GROUP_LANES*g+l] = data[DATA_BEATS*GROUP_LANES*g+GROUP_LANES*l+sk];
            if (w != WCC_X4 && flag_en)
              f[k][MASK_LANE+g] = flags[GROUP_LANES*g+sk];
          end
        end
        if (crc_on)
        begin
          c = wcc_crc8(wcc_code_word(f, g, w == WCC_X4));
          for (int l = 0; l < CRC_BITS; l++)
          begin
            if (w == WCC_X4)
            begin
              if (l < NARROW_LANES)
                f[CRC_BEAT][l] = c[l];
              else
                f[CRC_BEAT_HI][l-NARROW_LANES] = c[l];
            end
            else
              f[CRC_BEAT][GROUP_LANES*g+l] = c[l];
          end
        end
      end
    end
    return f;
  endfunction

  // ==========================================================================
  // State
  wcc_tx_state_t state;
  wcc_tx_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  wcc_frame_t tx;
  wcc_frame_t next_tx;
  logic beat_valid;
  logic next_beat_valid;
  logic [LANE_BITS-1:0] beat;
  logic [LANE_BITS-1:0] next_beat;
  logic [2:0] wait_cnt;
  logic [2:0] next_wait_cnt;
  logic seen;
  logic next_seen;
  logic can_retry;
  logic next_can_retry;
  logic next_req_ready;
  logic next_req_refused;
  logic next_crc_fail;

  assign link.beat_valid = beat_valid;
  assign link.beat = beat;

  // ==========================================================================
  // Next values
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_tx = tx;
    next_beat_valid = 1'b0;
    next_beat = beat;
    next_wait_cnt = wait_cnt;
    next_seen = seen;
    next_can_retry = can_retry;
    next_req_refused = 1'b0;
    next_crc_fail = 1'b0;
    case (state)
      WCC_TX_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          if (req_special && crc_en)
            next_req_refused = 1'b1;
          else
          begin
            next_tx = build_frame(req_data, req_flags, width, mask_en | inv_en, chop_en, req_a2, crc_en);
            next_can_retry = 1'b1;
            next_cnt = CNT_RESET;
            next_state = WCC_TX_SEND;
          end
        end
      end
      WCC_TX_SEND:
      begin
        // The first beat waits for buffer room at the memory end.
        if (cnt != CNT_RESET || link.link_ready)
        begin
          next_beat_valid = 1'b1;
          next_beat = tx[cnt];
          next_cnt = cnt + 4'h1;
          if (cnt == (crc_en ? LAST_BEAT_CRC : LAST_BEAT_PLAIN))
          begin
            next_cnt = CNT_RESET;
            next_wait_cnt = CHECK_WAIT_CYCLES;
            next_seen = 1'b0;
            next_state = WCC_TX_WAIT;
          end
        end
      end
      WCC_TX_WAIT:
      begin
        if (!link.alert_n && !seen)
        begin
          next_seen = 1'b1;
          next_crc_fail = 1'b1;
        end
        if (wait_cnt == 3'h0)
        begin
          // Unmasked writes may have landed corrupted, so resend them once.
          if (seen && !mask_en && can_retry)
          begin
            next_can_retry = 1'b0;
            next_state = WCC_TX_SEND;
          end
          else
            next_state = WCC_TX_IDLE;
        end
        else
          next_wait_cnt = wait_cnt - 3'h1;
      end
      default:
      begin
        next_state = WCC_TX_IDLE;
      end
    endcase
    next_req_ready = (next_state == WCC_TX_IDLE);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= WCC_TX_IDLE;
      cnt <= CNT_RESET;
      tx <= '1;
      beat_valid <= 1'b0;
      beat <= '1;
      wait_cnt <= 3'h0;
      seen <= 1'b0;
      can_retry <= 1'b0;
      req_ready <= 1'b0;
      req_refused <= 1'b0;
      crc_fail <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      cnt <= next_cnt;
      tx <= next_tx;
      beat_valid <= next_beat_valid;
      beat <= next_beat;
      wait_cnt <= next_wait_cnt;
      seen <= next_seen;
      can_retry <= next_can_retry;
      req_ready <= next_req_ready;
      req_refused <= next_req_refused;
      crc_fail <= next_crc_fail;
    end
  end

endmodule

// ===== testbench/wcc_link_chk.sv
// Assertions on the write frame link between the controller end and the memory end.
`timescale 1ns/1ns
module wcc_link_chk
  import wcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic beat_valid,
  input wire logic [LANE_BITS-1:0] beat,
  input wire logic alert_n,
  input wire logic link_ready
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // The counter holds the index of the beat now on the link.
  always_comb
  begin
    next_cnt = (rst || !beat_valid) ? 4'h0 : cnt + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    cnt <= next_cnt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_frame_ten_beats: assert property ($rose(beat_valid) |-> ##9 (beat_valid && cnt == 4'h9) ##1 !beat_valid)
    else $error("write frame is not ten beats long");
  a_beats_back_to_back: assert property (beat_valid && cnt < 4'h9 |=> beat_valid)
    else $error("gap inside a write frame");
  a_frame_ends: assert property (beat_valid && cnt == 4'h9 |=> !beat_valid)
    else $error("beat after the tenth beat");
  a_count_bound: assert property (beat_valid |-> cnt <= 4'h9)
    else $error("beat index beyond nine");
  a_start_when_ready: assert property ($rose(beat_valid) |-> $past(link_ready))
    else $error("frame started while the buffer was full");
  a_mask_lane_ones: assert property (beat_valid && cnt >= 4'h8 |-> beat[17:16] == 2'b11)
    else $error("mask lanes not high in checksum beats");
  a_no_false_alert: assert property (alert_n)
    else $error("alert raised on a correct frame");
  a_reset_idle: assert property ($past(rst) |-> !beat_valid && alert_n && link_ready)
    else $error("link not idle after reset");

  c_frame: cover property ($rose(beat_valid));
  c_full: cover property ($fell(link_ready));
  c_next_frame: cover property ($fell(beat_valid) ##[1:12] $rose(beat_valid));
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench: both ends joined, plus a fault-injecting driver on a second link.
`timescale 1ns/1ns
module tb_top;
  import wcc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, crc_en = 1'b1, mask_en = 1'b0, inv_en = 1'b0, chop_en = 1'b0;
  logic req_valid = 1'b0, req_a2 = 1'b0, req_special = 1'b0, arr_ready = 1'b0, stall = 1'b0;
  wcc_width_t width = WCC_X16;
  logic [DATA_BITS-1:0] req_data = '0, last_data = '0, arr_data;
  logic [MASK_BITS-1:0] req_flags = '1, last_flags = '1, arr_mask;
  logic req_ready, req_refused, crc_fail, arr_valid, crc_error, arr_valid2, crc_error2;
  logic [DATA_BITS-1:0] q_data[$], q_keep[$];
  logic [MASK_BITS-1:0] q_mask[$];
  logic [LANE_BITS-1:0] fr[FRAME_BEATS];
  logic [CW_BITS-1:0] flips[5] = '{72'h0, 72'h80_0000_0000_0000_0000, 72'h100_0000_0001, 72'hFF00_0000, 72'h7};
  integer seed = 51, fails = 0, tests_run = 0;
  int nb = 0;

  wcc_link_if link ();
  wcc_link_if link2 ();
  wcc_ctrl_end wcc_ctrl_end_inst (.clk(clk), .rst(rst), .ce(1'b1), .link(link.ctrl), .width(width),
    .crc_en(crc_en), .mask_en(mask_en), .inv_en(inv_en), .chop_en(chop_en), .req_valid(req_valid),
    .req_ready(req_ready), .req_data(req_data), .req_flags(req_flags), .req_a2(req_a2),
    .req_special(req_special), .req_refused(req_refused), .crc_fail(crc_fail));
  wcc_dram_end wcc_dram_end_inst (.clk(clk), .rst(rst), .ce(1'b1), .link(link.dram), .width(width),
    .crc_en(crc_en), .mask_en(mask_en), .inv_en(inv_en), .chop_en(chop_en), .chop_a2(req_a2),
    .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_data(arr_data), .arr_mask(arr_mask), .crc_error(crc_error));
  wcc_dram_end wcc_dram_end_inst2 (.clk(clk), .rst(rst), .ce(1'b1), .link(link2.dram), .width(width),
    .crc_en(crc_en), .mask_en(mask_en), .inv_en(inv_en), .chop_en(chop_en), .chop_a2(req_a2),
    .arr_valid(arr_valid2), .arr_ready(1'b1), .arr_data(), .arr_mask(), .crc_error(crc_error2));
  wcc_link_chk wcc_link_chk_inst (.clk(clk), .rst(rst), .beat_valid(link.beat_valid), .beat(link.beat),
    .alert_n(link.alert_n), .link_ready(link.link_ready));

  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    #10;
    arr_ready = !stall && $random(seed) % 2 != 0;
  end

  task automatic check(input logic [DATA_BITS-1:0] seen, input logic [DATA_BITS-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [CRC_BITS-1:0] ref_crc(input logic [CW_BITS-1:0] d);
    logic [CRC_BITS-1:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Always lets one edge pass, so a request never rises in the step in which the last one fell.
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge clk);
    #10;
    while (req_ready !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      #10;
      k++;
    end
    check(req_ready, 1'b1);
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (q_data.size() != 0 && k < 300)
    begin
      @(posedge clk);
      #10;
      k++;
    end
    check(q_data.size(), 0);
  endtask

  // Presents one request and notes the word the array must receive.
  task automatic send(input logic special, input wcc_width_t w, input logic [2:0] m);
    logic [DATA_BITS-1:0] d, keep;
    logic [MASK_BITS-1:0] mk;
    logic f, used;
    wait_ready();
    width = w;
    {chop_en, inv_en, mask_en} = m;
    req_data = {$random(seed), $random(seed), $random(seed), $random(seed)};
    req_flags = $random(seed);
    req_a2 = $random(seed);
    req_special = special;
    req_valid = 1'b1;
    last_data = req_data;
    last_flags = req_flags;
    d = req_data;
    keep = '0;
    mk = '1;
    for (int g = 0; g < 2; g++)
      for (int p = 0; p < 8; p++)
      begin
        f = req_flags[8*g+p] || w == WCC_X4;
        used = (g == 0 || w == WCC_X16) && (!m[2] || p[2] == req_a2);
        mk[8*g+p] = !used || (m[0] && !f);
        for (int l = 0; l < 8; l++)
        begin
          d[64*g+8*l+p] = d[64*g+8*l+p] ^ (m[1] && !m[0] && !f);
          keep[64*g+8*l+p] = !mk[8*g+p] && (l < 4 || w != WCC_X4);
        end
      end
    if (!(special && crc_en))
    begin
      q_data.push_back(d);
      q_keep.push_back(keep);
      q_mask.push_back(mk);
    end
    @(posedge clk);
    #10;
    req_valid = 1'b0;
    check(req_refused, special && crc_en);
  endtask

  task automatic frame_check(input int g);
    logic [CW_BITS-1:0] w;
    logic [CRC_BITS-1:0] c;
    logic x4;
    x4 = (width == WCC_X4);
    w = '1;
    for (int k = 0; k < 8; k++)
    begin
      for (int l = 0; l < 8; l++)
        w[8*l+k] = fr[k][8*g+l];
      w[64+k] = fr[k][16+g];
    end
    if (x4)
      w[71:32] = '1;
    for (int l = 0; l < 8; l++)
      c[l] = x4 ? fr[8+l/4][l%4] : fr[8][8*g+l];
    check(c, ref_crc(w));
    check(c[0], ^(w & 72'h3D_9177_298C_D0AD_51C1));
    if (!x4)
      check(fr[9][8*g+:8], 8'hFF);
    if (chop_en)
      check(fr[4] & fr[5] & fr[6] & fr[7], 18'h3FFFF);
    else
      check(x4 ? w[31:0] : w[63:0], x4 ? last_data[31:0] : last_data[64*g+:64]);
    if (!x4 && !chop_en)
      check(w[71:64], (mask_en || inv_en) ? last_flags[8*g+:8] : 8'hFF);
  endtask

  always @(posedge clk)
  begin
    if (crc_fail !== 1'b0 || crc_error !== 1'b0)
      check({crc_fail, crc_error}, 2'b00);
    if (link.beat_valid === 1'b1)
    begin
      if (nb < FRAME_BEATS)
        fr[nb] = link.beat;
      nb++;
    end
    else if (nb > 0)
    begin
      check(nb, FRAME_BEATS);
      frame_check(0);
      if (width == WCC_X16)
        frame_check(1);
      nb = 0;
    end
  end

  always @(posedge clk)
  begin
    if (arr_valid === 1'b1 && arr_ready === 1'b1)
    begin
      if (q_data.size() == 0)
        check(1'b1, 1'b0);
      else
      begin
        check(arr_data & q_keep[0], q_data[0] & q_keep[0]);
        check(arr_mask, q_mask[0]);
        void'(q_data.pop_front());
        void'(q_keep.pop_front());
        void'(q_mask.pop_front());
      end
    end
  end

  // Drives one byte-wide frame on the second link with the given bits flipped after the checksum.
  task automatic inject(input logic [CW_BITS-1:0] flip, input logic m);
    logic [CW_BITS-1:0] w;
    logic [CRC_BITS-1:0] c;
    logic [LANE_BITS-1:0] b;
    int na, ne, nv;
    w = {8'hFF, $random(seed), $random(seed)};
    c = ref_crc(w);
    w = w ^ flip;
    mask_en = m;
    na = 0;
    ne = 0;
    nv = 0;
    for (int k = 0; k < 24; k++)
    begin
      b = '1;
      for (int l = 0; l < 8; l++)
        b[l] = k < 8 ? w[8*l+k] : (k == 8 ? c[l] : 1'b1);
      if (k < 8)
        b[16] = w[64+k];
      link2.beat_valid = k < 10;
      link2.beat = b;
      @(posedge clk);
      #10;
      na += link2.alert_n === 1'b0;
      ne += crc_error2 === 1'b1;
      nv += arr_valid2 === 1'b1;
    end
    check(na, flip != 0 ? 6 : 0);
    check(ne, flip != 0);
    check(nv, !(m && flip != 0));
  endtask

  initial
  begin
    link2.beat_valid = 1'b0;
    link2.beat = '1;
    repeat (20) @(posedge clk);
    #10;
    rst = 1'b0;
    for (int w = 0; w < 3; w++)
      for (int m = 0; m < 8; m++)
        send(1'b0, wcc_width_t'(w), m[2:0]);
    send(1'b1, WCC_X8, 3'h0);
    drain();
    stall = 1'b1;
    send(1'b0, WCC_X16, 3'h1);
    send(1'b0, WCC_X16, 3'h2);
    wait_ready();
    check(link.link_ready, 1'b0);
    send(1'b0, WCC_X16, 3'h0);
    repeat (30) @(posedge clk);
    #10;
    check(link.beat_valid, 1'b0);
    stall = 1'b0;
    drain();
    wait_ready();
    width = WCC_X8;
    chop_en = 1'b0;
    inv_en = 1'b0;
    for (int i = 0; i < 10; i++)
      inject(flips[i/2], i % 2 != 0);
    end_sim();
  end

  initial
  begin
    #2000000;
    fails++;
    end_sim();
  end
endmodule
